/* File: src/tlss_defs.svh */
// Purpose: Constants of the two-level supply sequencer
// Assumes: 200 MHz clock, classic Wishbone with 32-bit data
// Notes:   Offsets are byte addresses
`ifndef TLSS_DEFS_SVH
`define TLSS_DEFS_SVH

// ==========================================================================
// Timing
// ==========================================================================
`define TLSS_CLK_MHZ        200
`define TLSS_READY_US       500
`define TLSS_READY_CYC      (`TLSS_READY_US * `TLSS_CLK_MHZ)
`define TLSS_INIT_US        500
`define TLSS_INIT_CYC       (`TLSS_INIT_US * `TLSS_CLK_MHZ)

// ==========================================================================
// Register offsets
// ==========================================================================
`define TLSS_OFF_STATUS     8'h00
`define TLSS_OFF_IRQ_STAT   8'h04
`define TLSS_OFF_IRQ_MASK   8'h08
`define TLSS_OFF_CONFIG     8'h0C
`define TLSS_OFF_VCC_ADC    8'h10
`define TLSS_OFF_VCC_LIMIT  8'h14
`define TLSS_OFF_NV_ADDR    8'h18
`define TLSS_OFF_NV_CFG     8'h1C

// ==========================================================================
// Fields and reset values
// ==========================================================================
`define TLSS_ST_NOT_READY   0
`define TLSS_ST_VCC_LOW     1
`define TLSS_ST_ANALOG_ON   2
`define TLSS_ST_RECALLED    3
`define TLSS_ST_TXFAULT     4
`define TLSS_ST_LOS_SEL     5
`define TLSS_CFG_ADDR_NV    0
`define TLSS_CFG_LOS_SEL    1
`define TLSS_CFG_TXF_IN     2
`define TLSS_EV_RECALL      0
`define TLSS_EV_BROWNOUT    1
`define TLSS_EV_DIG_LOSS    2
`define TLSS_EV_READY       3
`define TLSS_NEV            4
`define TLSS_DEF_ADDR       8'hA2
`define TLSS_RST_LIMIT      16'h0000
`define TLSS_RST_NV_ADDR    8'hA2

`endif

/* File: src/tlss_pkg.sv */
// Purpose: Types of the two-level supply sequencer
// Assumes: Constants live in tlss_defs.svh
// Notes:   One-hot sequencing states
package tlss_pkg;

   typedef enum logic [4:0] {
      TLSS_DEAD   = 5'b0_0001,
      TLSS_RECALL = 5'b0_0010,
      TLSS_SETTLE = 5'b0_0100,
      TLSS_RUN    = 5'b0_1000,
      TLSS_BROWN  = 5'b1_0000
   } tlss_state_t;

endpackage

/* File: src/tlss_sync.sv */
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Asynchronous level input
// Notes:   Output changes once stages two and three agree
`timescale 1ns/10ps
module tlss_sync (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic async_i,
   output logic      level_o
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= async_i;
         s2 <= s1;
         s3 <= s2;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_o <= 1'b0;
      end else if (s2 == s3) begin
         level_o <= s3;
      end
   end
endmodule // tlss_sync

/* File: src/tlss_timer.sv */
// Purpose: Delay counter that raises done after a set count
// Assumes: run_i held high while timing, low clears
// Notes:   done stays high while run_i stays high
`timescale 1ns/10ps
module tlss_timer #(
   parameter int unsigned COUNT = 100
) (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic run_i,
   output logic      done_o
);
   logic [23:0] cnt;

   always_ff @(posedge clk_i) begin
      if (rst_i || !run_i) begin
         cnt    <= 24'h00_0000;
         done_o <= 1'b0;
      end else if (!done_o) begin
         if (cnt == 24'(COUNT - 1)) begin
            done_o <= 1'b1;
         end
         cnt <= cnt + 24'h00_0001;
      end
   end
endmodule // tlss_timer

/* File: src/tlss_top.sv */
// Purpose: Two-level supply sequencer with Wishbone register access
// Assumes: Supply detector levels are asynchronous, high above threshold
// Notes:   Nonvolatile copy arrives on nv_* inputs, recall takes one cycle
`timescale 1ns/10ps
`include "tlss_defs.svh"
module tlss_top #(
   parameter int unsigned READY_CYC = `TLSS_READY_CYC,
   parameter int unsigned INIT_CYC  = `TLSS_INIT_CYC
) (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        analog_supply_threshold_i,
   input  wire logic        digital_supply_threshold_i,
   input  wire logic [7:0]  nv_addr_i,
   input  wire logic        nv_los_sel_i,
   input  wire logic        adc_valid_i,
   input  wire logic [15:0] adc_vcc_i,
   input  wire logic        transmit_fault_signal_i,
   input  wire logic        fault_latch_i,
   input  wire logic        sigma_delta_one_i,
   input  wire logic        sigma_delta_two_i,
   input  wire logic        tx_disable_i,
   input  wire logic        los_pin_i,
   input  wire logic        los_quick_i,
   output logic             analog_en_o,
   output logic             outputs_en_o,
   output logic             not_ready_flag_o,
   output logic             supply_low_alarm_o,
   output logic             transmit_fault_output_o,
   output logic [7:0]       slave_addr_o,
   output logic             sigma_delta_out_one_o,
   output logic             sigma_delta_out_one_oe_o,
   output logic             sigma_delta_out_two_o,
   output logic             sigma_delta_out_two_oe_o,
   output logic             transmit_disable_output_o,
   output logic             transmit_disable_output_oe_o,
   output logic             signal_loss_output_o,
   output logic             irq_o
);
   tlss_pkg::tlss_state_t state;
   tlss_pkg::tlss_state_t next_state;
   logic        ana_ok;
   logic        dig_ok;
   logic        ready_done;
   logic        init_done;
   logic        recalled;
   logic [7:0]  addr_shadow;
   logic        los_sel_shadow;
   logic        addr_from_nv;
   logic        vcc_good_seen;
   logic [15:0] vcc_last;
   logic [15:0] vcc_limit;
   logic [2:0]  cfg;
   logic [`TLSS_NEV-1:0] ev_stat;
   logic [`TLSS_NEV-1:0] ev_mask;
   logic [`TLSS_NEV-1:0] ev_set;
   logic        fault_latched;
   logic        fault_raw;
   logic        running;
   logic        wb_hit;
   logic [31:0] rd_data;

   // ========================================================================
   // Detector synchronisers
   // ========================================================================
   tlss_sync u_sync_ana (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i (analog_supply_threshold_i),
      .level_o (ana_ok)
   );

   tlss_sync u_sync_dig (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .async_i (digital_supply_threshold_i),
      .level_o (dig_ok)
   );

   // ========================================================================
   // Sequencing
   // ========================================================================
   always_comb begin
      next_state = state;
      case (state)
         tlss_pkg::TLSS_DEAD: begin
            if (dig_ok && ana_ok) begin
               next_state = tlss_pkg::TLSS_RECALL;
            end
         end
         tlss_pkg::TLSS_RECALL: begin
            next_state = tlss_pkg::TLSS_SETTLE;
         end
         tlss_pkg::TLSS_SETTLE, tlss_pkg::TLSS_RUN: begin
            if (!dig_ok) begin
               next_state = tlss_pkg::TLSS_DEAD;
            end else if (!ana_ok) begin
               next_state = tlss_pkg::TLSS_BROWN;
            end else if (state == tlss_pkg::TLSS_SETTLE && ready_done) begin
               next_state = tlss_pkg::TLSS_RUN;
            end
         end
         tlss_pkg::TLSS_BROWN: begin
            if (!dig_ok) begin
               next_state = tlss_pkg::TLSS_DEAD;
            end else if (ana_ok) begin
               next_state = tlss_pkg::TLSS_RUN;
            end
         end
         default: next_state = tlss_pkg::TLSS_DEAD;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= tlss_pkg::TLSS_DEAD;
      end else begin
         state <= next_state;
      end
   end

   assign running = (state == tlss_pkg::TLSS_SETTLE) ||
                    (state == tlss_pkg::TLSS_RUN);

   // Ready window restarts only on power-up out of TLSS_DEAD; brownout recovery goes straight to TLSS_RUN
   tlss_timer #(.COUNT(READY_CYC)) u_ready (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .run_i  (state == tlss_pkg::TLSS_SETTLE),
      .done_o (ready_done)
   );

   // Init delay spans the whole powered period, not reset by brownout
   tlss_timer #(.COUNT(INIT_CYC)) u_init (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .run_i  (recalled),
      .done_o (init_done)
   );

   // ========================================================================
   // Shadowed nonvolatile copy
   // ========================================================================
   always_ff @(posedge clk_i) begin
      if (rst_i || state == tlss_pkg::TLSS_DEAD) begin
         recalled       <= 1'b0;
         addr_shadow    <= 8'h00;
         los_sel_shadow <= 1'b0;
      end else if (state == tlss_pkg::TLSS_RECALL) begin
         recalled       <= 1'b1;
         addr_shadow    <= nv_addr_i;
         los_sel_shadow <= nv_los_sel_i;
      end
   end

   // ========================================================================
   // Supply-low alarm and fault
   // ========================================================================
   always_ff @(posedge clk_i) begin
      if (rst_i || !running) begin
         supply_low_alarm_o <= 1'b1;
         vcc_good_seen      <= 1'b0;
      end else if (adc_valid_i) begin
         if (adc_vcc_i > vcc_limit) begin
            supply_low_alarm_o <= 1'b0;
            vcc_good_seen      <= 1'b1;
         end else begin
            supply_low_alarm_o <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         vcc_last <= 16'h0000;
      end else if (adc_valid_i) begin
         vcc_last <= adc_vcc_i;
      end
   end

   // Supply-low term bypasses any mask
   assign fault_raw = supply_low_alarm_o ||
                      (cfg[`TLSS_CFG_TXF_IN] && transmit_fault_signal_i);

   always_ff @(posedge clk_i) begin
      if (rst_i || !running) begin
         fault_latched <= 1'b0;
      end else if (vcc_good_seen && fault_latch_i && fault_raw) begin
         fault_latched <= 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         transmit_fault_output_o <= 1'b1;
      end else begin
         transmit_fault_output_o <= !running || fault_raw ||
                                    fault_latched;
      end
   end

   // ========================================================================
   // Outputs and enables
   // ========================================================================
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         analog_en_o                  <= 1'b0;
         outputs_en_o                 <= 1'b0;
         not_ready_flag_o             <= 1'b1;
         slave_addr_o                 <= `TLSS_DEF_ADDR;
         sigma_delta_out_one_o        <= 1'b0;
         sigma_delta_out_one_oe_o     <= 1'b0;
         sigma_delta_out_two_o        <= 1'b0;
         sigma_delta_out_two_oe_o     <= 1'b0;
         transmit_disable_output_o    <= 1'b0;
         transmit_disable_output_oe_o <= 1'b0;
         signal_loss_output_o         <= 1'b0;
      end else begin
         analog_en_o      <= running;
         outputs_en_o     <= running;
         not_ready_flag_o <= state != tlss_pkg::TLSS_RUN;
         slave_addr_o     <= (recalled && addr_from_nv) ?
                             addr_shadow : `TLSS_DEF_ADDR;
         sigma_delta_out_one_o    <= sigma_delta_one_i;
         sigma_delta_out_two_o    <= sigma_delta_two_i;
         sigma_delta_out_one_oe_o <= running && init_done;
         sigma_delta_out_two_oe_o <= running && init_done;
         transmit_disable_output_o    <= tx_disable_i ||
                                         transmit_fault_output_o;
         transmit_disable_output_oe_o <= running;
         signal_loss_output_o <= running &&
            ((recalled && !los_sel_shadow) ? los_quick_i
                                           : los_pin_i);
      end
   end

   // ========================================================================
   // Interrupts
   // ========================================================================
   assign ev_set[`TLSS_EV_RECALL]   = state == tlss_pkg::TLSS_RECALL;
   assign ev_set[`TLSS_EV_BROWNOUT] = running &&
                                      next_state == tlss_pkg::TLSS_BROWN;
   assign ev_set[`TLSS_EV_DIG_LOSS] = state != tlss_pkg::TLSS_DEAD &&
                                      next_state == tlss_pkg::TLSS_DEAD;
   assign ev_set[`TLSS_EV_READY]    = state != tlss_pkg::TLSS_RUN &&
                                      next_state == tlss_pkg::TLSS_RUN;

   genvar gi;
   generate
      for (gi = 0; gi < `TLSS_NEV; gi++) begin : g_ev
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               ev_stat[gi] <= 1'b0;
            end else if (ev_set[gi]) begin
               ev_stat[gi] <= 1'b1;
            end else if (wb_hit && wb_we_i && wb_sel_i[0] &&
                         wb_adr_i == `TLSS_OFF_IRQ_STAT &&
                         wb_dat_i[gi]) begin
               ev_stat[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(ev_stat & ev_mask);
      end
   end

   // ========================================================================
   // Wishbone slave
   // ========================================================================
   assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ev_mask      <= '0;
         cfg          <= 3'b000;
         vcc_limit    <= `TLSS_RST_LIMIT;
         addr_from_nv <= 1'b0;
      end else if (wb_hit && wb_we_i) begin
         case (wb_adr_i)
            `TLSS_OFF_IRQ_MASK: begin
               if (wb_sel_i[0]) ev_mask <= wb_dat_i[`TLSS_NEV-1:0];
            end
            `TLSS_OFF_CONFIG: begin
               if (wb_sel_i[0]) begin
                  cfg          <= wb_dat_i[2:0];
                  addr_from_nv <= wb_dat_i[`TLSS_CFG_ADDR_NV];
               end
            end
            `TLSS_OFF_VCC_LIMIT: begin
               if (wb_sel_i[0]) vcc_limit[7:0]  <= wb_dat_i[7:0];
               if (wb_sel_i[1]) vcc_limit[15:8] <= wb_dat_i[15:8];
            end
            default: ;
         endcase
      end
   end

   always_comb begin
      rd_data = 32'h0000_0000;
      case (wb_adr_i)
         `TLSS_OFF_STATUS: begin
            rd_data[`TLSS_ST_NOT_READY] = not_ready_flag_o;
            rd_data[`TLSS_ST_VCC_LOW]   = supply_low_alarm_o;
            rd_data[`TLSS_ST_ANALOG_ON] = analog_en_o;
            rd_data[`TLSS_ST_RECALLED]  = recalled;
            rd_data[`TLSS_ST_TXFAULT]   = transmit_fault_output_o;
            rd_data[`TLSS_ST_LOS_SEL]   = los_sel_shadow;
         end
         `TLSS_OFF_IRQ_STAT:  rd_data[`TLSS_NEV-1:0] = ev_stat;
         `TLSS_OFF_IRQ_MASK:  rd_data[`TLSS_NEV-1:0] = ev_mask;
         `TLSS_OFF_CONFIG:    rd_data[2:0] = cfg;
         `TLSS_OFF_VCC_ADC:   rd_data[15:0] = vcc_last;
         `TLSS_OFF_VCC_LIMIT: rd_data[15:0] = vcc_limit;
         `TLSS_OFF_NV_ADDR:   rd_data[7:0] = slave_addr_o;
         `TLSS_OFF_NV_CFG:    rd_data[0] = los_sel_shadow;
         default:             rd_data = 32'h0000_0000;
      endcase
   end

   // Unmapped addresses still ack and read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_hit;
         wb_dat_o <= rd_data;
      end
   end
endmodule // tlss_top

/* File: verif/tlss_top_sva.sv */
// Purpose: Port assertions for the two-level supply sequencer
// Assumes: One clock, synchronous active high reset
// Notes:   Attached by a bind in the bench top
`timescale 1ns/10ps
module tlss_top_sva #(
   parameter int unsigned READY_CYC = 20
) (
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic       analog_supply_threshold_i,
   input wire logic       digital_supply_threshold_i,
   input wire logic       analog_en_o,
   input wire logic       outputs_en_o,
   input wire logic       not_ready_flag_o,
   input wire logic       supply_low_alarm_o,
   input wire logic       transmit_fault_output_o,
   input wire logic [7:0] slave_addr_o,
   input wire logic       sigma_delta_out_one_oe_o,
   input wire logic       sigma_delta_out_two_oe_o,
   input wire logic       transmit_disable_output_oe_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // ======================================================================
   // Helpers
   // ======================================================================
   // Cycles spent powered but not yet ready
   int unsigned wait_cnt;
   always_ff @(posedge clk_i) begin
      if (rst_i || !analog_en_o || !not_ready_flag_o) begin
         wait_cnt <= 0;
      end else begin
         wait_cnt <= wait_cnt + 1;
      end
   end

   // Two cycles unpowered, so registered flags have caught up
   sequence s_off2;
      !analog_en_o ##1 !analog_en_o;
   endsequence

   sequence s_shut;
      !analog_en_o && !outputs_en_o && !transmit_disable_output_oe_o;
   endsequence

   // ======================================================================
   // Assertions
   // ======================================================================
   a_nrdy_off: assert property (s_off2 |-> not_ready_flag_o)
      else $error("not-ready flag low while unpowered");
   a_alarm_off: assert property (s_off2 |-> supply_low_alarm_o)
      else $error("supply-low alarm low while unpowered");
   a_txf_off: assert property (s_off2 |-> transmit_fault_output_o)
      else $error("transmit fault low while unpowered");
   a_sd_float: assert property (
      (sigma_delta_out_one_oe_o || sigma_delta_out_two_oe_o)
      |-> (analog_en_o || $past(analog_en_o)))
      else $error("sigma-delta output driven while unpowered");
   a_txd_float: assert property (
      transmit_disable_output_oe_o |-> (analog_en_o || $past(analog_en_o)))
      else $error("transmit-disable driven while unpowered");
   a_rise_cause: assert property (
      $rose(analog_en_o) |-> ($past(analog_supply_threshold_i, 2)
                              && $past(digital_supply_threshold_i, 2)))
      else $error("analog enabled without synchronised detectors");
   a_brown_shut: assert property (
      $fell(analog_supply_threshold_i) |-> ##[1:10] s_shut)
      else $error("brownout did not shut analog and outputs");
   a_dig_loss: assert property (
      $fell(digital_supply_threshold_i) |-> ##[1:10]
      (!analog_en_o && not_ready_flag_o && slave_addr_o == 8'hA2))
      else $error("digital loss did not return to defaults");
   a_ready_bound: assert property (wait_cnt <= READY_CYC + 3)
      else $error("not-ready flag held too long");
endmodule // tlss_top_sva

/* File: verif/tlss_supply_model.sv */
// Purpose: Supply detectors, nonvolatile copy and supply ADC
// Assumes: Commanded by the bench through tasks
// Notes:   Conversion data is scrambled outside its valid pulse
`timescale 1ns/10ps
module tlss_supply_model (
   input  wire logic        clk_i,
   output logic             analog_o,
   output logic             digital_o,
   output logic [7:0]       nv_addr_o,
   output logic             nv_los_sel_o,
   output logic             adc_valid_o,
   output logic [15:0]      adc_vcc_o
);
   initial begin
      analog_o = 1'b0;
      digital_o = 1'b0;
      nv_addr_o = 8'h5C;
      nv_los_sel_o = 1'b0;
      adc_valid_o = 1'b0;
      adc_vcc_o = 16'hFFFF;
   end

   task automatic set_supply(input logic a, input logic d);
      @(posedge clk_i);
      analog_o <= a;
      digital_o <= d;
   endtask

   task automatic set_nv(input logic [7:0] a, input logic s);
      @(posedge clk_i);
      nv_addr_o <= a;
      nv_los_sel_o <= s;
   endtask

   task automatic convert(input logic [15:0] v);
      @(posedge clk_i);
      adc_valid_o <= 1'b1;
      adc_vcc_o <= v;
      @(posedge clk_i);
      adc_valid_o <= 1'b0;
      adc_vcc_o <= ~v;
   endtask
endmodule // tlss_supply_model

/* File: verif/tb_top.sv */
// Purpose: Self-checking bench of the two-level supply sequencer
// Assumes: Shortened ready and init counts
// Notes:   Register access over classic Wishbone
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
   begin \
      n_tests++; \
      if ((got) !== (ex)) begin \
         errors++; \
         $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); \
      end \
   end
module tb_top;
   localparam int RDY = 20;
   localparam int INI = 30;
   logic        clk_i, rst_i, cyc, stb, we, los_pin, los_quick;
   logic [7:0]  adr;
   logic [3:0]  sel;
   logic [31:0] wdat, q;
   logic [31:0] rdat;
   logic        ack, aen, oen, nrdy, alarm, transmit_fault_signal, sd1, sd1oe, sd2, sd2oe;
   logic        txd, txdoe, los_o, irq, a_lvl, d_lvl, nv_los, adc_v;
   logic        txf_in, f_latch;
   logic [7:0]  saddr, nv_addr;
   logic [15:0] adc_d;
   int          errors, n_tests;

   tlss_supply_model sup_u (.clk_i(clk_i), .analog_o(a_lvl),
      .digital_o(d_lvl), .nv_addr_o(nv_addr), .nv_los_sel_o(nv_los),
      .adc_valid_o(adc_v), .adc_vcc_o(adc_d));

   tlss_top #(.READY_CYC(RDY), .INIT_CYC(INI)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .analog_supply_threshold_i(a_lvl),
      .digital_supply_threshold_i(d_lvl), .nv_addr_i(nv_addr),
      .nv_los_sel_i(nv_los), .adc_valid_i(adc_v), .adc_vcc_i(adc_d),
      .transmit_fault_signal_i(txf_in), .fault_latch_i(f_latch),
      .sigma_delta_one_i(1'b1), .sigma_delta_two_i(1'b0),
      .tx_disable_i(1'b0), .los_pin_i(los_pin), .los_quick_i(los_quick),
      .analog_en_o(aen), .outputs_en_o(oen), .not_ready_flag_o(nrdy),
      .supply_low_alarm_o(alarm), .transmit_fault_output_o(transmit_fault_signal),
      .slave_addr_o(saddr), .sigma_delta_out_one_o(sd1),
      .sigma_delta_out_one_oe_o(sd1oe), .sigma_delta_out_two_o(sd2),
      .sigma_delta_out_two_oe_o(sd2oe), .transmit_disable_output_o(txd),
      .transmit_disable_output_oe_o(txdoe), .signal_loss_output_o(los_o),
      .irq_o(irq));

   // ======================================================================
   // Bus and timing helpers
   // ======================================================================
   task automatic settle(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // Bounded wait: a slave that never acks must not hang the run
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= 4'h3;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      `CHK("ack", 1'b1, ack)
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   // ======================================================================
   // Scenarios
   // ======================================================================
   task automatic t_dead();
      sup_u.set_supply(1'b0, 1'b1);
      settle(10);
      `CHK("analog_en", 1'b0, aen)
      `CHK("outputs_en", 1'b0, oen)
      `CHK("alarm", 1'b1, alarm)
      `CHK("tx_fault", 1'b1, transmit_fault_signal)
      `CHK("addr", 8'hA2, saddr)
      `CHK("sd_oe", 2'b00, {sd1oe, sd2oe})
      `CHK("txd_oe", 1'b0, txdoe)
      `CHK("los_out", 1'b0, los_o)
      wb(1'b0, 8'h00, 32'h0000_0000);
      `CHK("status", 5'h13, q[4:0])
      wb(1'b0, 8'h14, 32'h0000_0000);
      `CHK("limit", 32'h0000_0000, q)
      wb(1'b0, 8'h30, 32'h0000_0000);
      `CHK("unmapped", 32'h0000_0000, q)
      wb(1'b1, 8'h0C, 32'h0000_0001);
      wb(1'b1, 8'h14, 32'h0000_1000);
      wb(1'b1, 8'h08, 32'h0000_000F);
      wb(1'b1, 8'h04, 32'h0000_000F);
      settle(2);
      `CHK("irq_idle", 1'b0, irq)
   endtask

   task automatic t_power_up();
      sup_u.set_supply(1'b1, 1'b1);
      settle(10);
      `CHK("analog_en", 1'b1, aen)
      `CHK("addr", 8'h5C, saddr)
      `CHK("not_ready", 1'b1, nrdy)
      `CHK("sd_oe", 2'b00, {sd1oe, sd2oe})
      `CHK("los_out", los_quick, los_o)
      `CHK("irq", 1'b1, irq)
      settle(RDY + 5);
      `CHK("not_ready", 1'b0, nrdy)
      `CHK("tx_fault", 1'b1, transmit_fault_signal)
      settle(INI);
      `CHK("sd_oe", 2'b11, {sd1oe, sd2oe})
      sup_u.convert(16'h1000);
      settle(3);
      `CHK("alarm", 1'b1, alarm)
      sup_u.convert(16'h1001);
      settle(3);
      `CHK("alarm", 1'b0, alarm)
      `CHK("tx_fault", 1'b0, transmit_fault_signal)
      `CHK("txd", 1'b0, txd)
      `CHK("sd_data", 2'b10, {sd1, sd2})
      wb(1'b0, 8'h04, 32'h0000_0000);
      `CHK("events", 4'h9, q[3:0])
      wb(1'b1, 8'h08, 32'h0000_0000);
      settle(2);
      `CHK("irq_masked", 1'b0, irq)
      wb(1'b1, 8'h08, 32'h0000_000F);
      wb(1'b1, 8'h04, 32'h0000_0009);
      settle(2);
      `CHK("irq_clear", 1'b0, irq)
      // Latching is allowed once a good conversion has been seen
      wb(1'b1, 8'h0C, 32'h0000_0005);
      f_latch <= 1'b1;
      txf_in <= 1'b1;
      repeat (3) @(posedge clk_i);
      txf_in <= 1'b0;
      settle(3);
      `CHK("txf_latched", 1'b1, transmit_fault_signal)
   endtask

   task automatic t_brownout();
      sup_u.set_nv(8'h66, 1'b1);
      los_quick <= 1'b1;
      los_pin <= 1'b0;
      sup_u.set_supply(1'b0, 1'b1);
      settle(10);
      `CHK("power", 3'b000, {aen, oen, txdoe})
      `CHK("not_ready", 1'b1, nrdy)
      `CHK("alarm", 1'b1, alarm)
      `CHK("tx_fault", 1'b1, transmit_fault_signal)
      `CHK("addr_kept", 8'h5C, saddr)
      sup_u.set_supply(1'b1, 1'b1);
      settle(10);
      `CHK("not_ready", 1'b0, nrdy)
      `CHK("addr_kept", 8'h5C, saddr)
      `CHK("los_out", 1'b1, los_o)
      wb(1'b0, 8'h04, 32'h0000_0000);
      `CHK("events", 2'b10, q[1:0])
   endtask

   task automatic t_dig_loss();
      sup_u.set_supply(1'b0, 1'b0);
      settle(10);
      `CHK("addr", 8'hA2, saddr)
      sup_u.set_supply(1'b0, 1'b1);
      wb(1'b1, 8'h0C, 32'h0000_0001);
      los_pin <= 1'b0;
      sup_u.set_supply(1'b1, 1'b1);
      settle(10);
      `CHK("addr", 8'h66, saddr)
      `CHK("not_ready", 1'b1, nrdy)
      `CHK("los_out", 1'b0, los_o)
   endtask

   // ======================================================================
   // Run control
   // ======================================================================
   task automatic complete_run();
      if (errors == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   // Whole run is a few hundred cycles; this is far beyond it
   initial begin
      #60000;
      errors++;
      complete_run();
   end

   initial begin
      errors = 0;
      n_tests = 0;
      rst_i = 1'b1;
      {cyc, stb, we, los_quick, txf_in, f_latch} = 6'h00;
      los_pin = 1'b1;
      adr = 8'h00;
      sel = 4'h0;
      wdat = 32'h0000_0000;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      t_dead();
      t_power_up();
      t_brownout();
      t_dig_loss();
      complete_run();
   end
endmodule // tb_top

bind tlss_top tlss_top_sva #(.READY_CYC(READY_CYC)) sva_u (
   .clk_i, .rst_i, .analog_supply_threshold_i, .digital_supply_threshold_i,
   .analog_en_o, .outputs_en_o, .not_ready_flag_o, .supply_low_alarm_o,
   .transmit_fault_output_o, .slave_addr_o, .sigma_delta_out_one_oe_o,
   .sigma_delta_out_two_oe_o, .transmit_disable_output_oe_o);
